//--- logic/ofic_pkg.sv
// Purpose: shared constants and types for the output fault and inhibit control block
// Assumes: 10 MHz system clock, register port with one-cycle read latency
// Notes: register indices and field positions are gathered here
package ofic_pkg;
    localparam int CLK_HZ = 10000000;
    // protection delay is held in milliseconds
    localparam int DELAY_MS_DEFAULT = 80;
    localparam int CYCLES_PER_MS = CLK_HZ / 1000;

    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_FISRC = 4'h1;
    localparam logic [3:0] ADDR_DELAY = 4'h2;
    localparam logic [3:0] ADDR_CMD = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_NVSET = 4'h5;

    localparam int CTRL_OUTEN = 0;
    localparam int CTRL_FIEN = 1;
    localparam int CTRL_OCPEN = 2;
    localparam int CTRL_OVPEN = 3;
    localparam int CMD_CLEAR = 0;
    localparam int NV_PON = 0;
    localparam int NV_MODE_LSB = 1;

    localparam int SB_QUESTIONABLE_SUMMARY_CHOICE = 3;
    localparam int SB_ESB = 5;
    localparam int SB_RQS = 6;
    localparam int SB_OPERATION_SUMMARY_CHOICE = 7;

    typedef enum logic [2:0] {
        FISRC_OFF = 3'h0,
        FISRC_QUESTIONABLE_SUMMARY_CHOICE = 3'h1,
        FISRC_OPERATION_SUMMARY_CHOICE = 3'h2,
        FISRC_ESB = 3'h3,
        FISRC_RQS = 3'h4
    } ofic_src_t;

    typedef enum logic [1:0] {
        RDM_OFF = 2'h0,
        RDM_LATCH = 2'h1,
        RDM_LIVE = 2'h2
    } ofic_mode_t;

    typedef enum logic [1:0] {
        PON_RESET = 2'h1,
        PON_SLOT0 = 2'h2
    } ofic_pon_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ofic_req_t;

    typedef struct packed {
        logic overVoltage;
        logic overTemp;
        logic ccRaw;
    } ofic_analog_t;
endpackage

//--- logic/output_fault_inhibit_control.sv
// Purpose: output enable, protection latch, inhibit handling and fault indicator of a dc source
// Assumes: inputs synchronous to mclk except inhibitInput; nv store outside loads nvLoad values
// Notes: register map: 0 ctrl, 1 indicator source, 2 delay ms, 3 command, 4 status, 5 stored settings
// What this block does
// - output enable setting; cleared means output held at zero; resets to 0
// - fault indicator has own enable, off after reset; line driven only when on
// - questionable choice drives indicator from status byte bit 3
// - operation choice drives indicator from status byte bit 7
// - standard event choice drives indicator from status byte bit 5
// - service request choice drives indicator from status byte bit 6
// - source choice none passes nothing; it is the reset value
// - power-on choice kept non-volatile: reset settings or slot zero recall
// - overvoltage, overcurrent, overtemperature or inhibit latches output off; clear releases
// - clear ignored while any fault cause is still present
// - successful clear restores output enable in effect before the fault
// - programmable delay, default 0.08 s, before recording constant current
// - overcurrent trip waits for the same delayed constant current record
// - overvoltage trip ignores that delay
// - inhibit mode kept in non-volatile storage
// - latching mode: inhibit driven low latches output off
// - latching mode: latch released only by clear while inhibit is high
// - live mode: output off while inhibit low, unaffected when high
// - off mode ignores inhibit entirely
// - overcurrent enabled and constant current: output off, overcurrent flag set
// - overvoltage trips with zero delay above the programmed level
`timescale 1ns/10ps
`default_nettype none
module output_fault_inhibit_control #(
    parameter int DELAY_MS_RESET = ofic_pkg::DELAY_MS_DEFAULT,
    parameter int CYCLES_PER_MS = ofic_pkg::CYCLES_PER_MS
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire ofic_pkg::ofic_req_t busReq,
    output logic [31:0] readData,
    input wire ofic_pkg::ofic_analog_t analogIn,
    input wire logic [7:0] statusByte,
    input wire logic inhibitInput,
    input wire logic nvLoad,
    input wire logic [7:0] nvData,
    output logic outputOn,
    output logic fault_indicator_out,
    output logic faultIndicatorOe,
    output logic constant_current_state,
    output logic overcurrent_trip,
    output logic overvoltage_trip,
    output logic recall_slot_zero_poweron,
    output logic nvWrite,
    output logic [7:0] nvWriteData
);
    logic outEnable;
    logic faultIndEnable;
    logic ocpEnable;
    logic ovpEnable;
    ofic_pkg::ofic_src_t faultSource;
    ofic_pkg::ofic_mode_t remote_disable_mode;
    ofic_pkg::ofic_pon_t ponChoice;
    logic [31:0] delayMs;
    logic inhMeta;
    logic inhSync;
    logic inhibitLatched;
    logic protLatched;
    logic savedEnable;
    logic [31:0] msCount;
    logic [31:0] cycleCount;
    logic msTick;
    logic ccRecorded;
    logic ocFlag;
    logic ovFlag;
    logic otFlag;
    logic selectedFlag;
    logic clearReq;
    logic causePresent;
    logic newFault;
    logic wrCtrl;
    logic clearOk;
    logic [7:0] next_nv;

    assign wrCtrl = busReq.wr && busReq.addr == ofic_pkg::ADDR_CTRL;
    assign clearReq = busReq.wr && busReq.addr == ofic_pkg::ADDR_CMD && busReq.wdata[ofic_pkg::CMD_CLEAR];
    // an inhibit still low only blocks the clear in latching mode
    assign causePresent = analogIn.overVoltage || analogIn.overTemp || constant_current_state
        || (remote_disable_mode == ofic_pkg::RDM_LATCH && !inhSync);
    assign newFault = (ovpEnable && analogIn.overVoltage)
        || (ocpEnable && constant_current_state)
        || analogIn.overTemp
        || (remote_disable_mode == ofic_pkg::RDM_LATCH && !inhSync);
    // every new fault is also a cause, so an accepted clear never meets a fresh fault
    assign clearOk = clearReq && !causePresent;

    // output enable; a write to ctrl in the clear cycle wins over the restore
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            outEnable <= 1'b0;
        end else if (wrCtrl) begin
            outEnable <= busReq.wdata[ofic_pkg::CTRL_OUTEN];
        end else if (clearOk && protLatched) begin
            outEnable <= savedEnable;
        end
    end

    // indicator and protection enables; overvoltage protection starts armed
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            faultIndEnable <= 1'b0;
            ocpEnable <= 1'b0;
            ovpEnable <= 1'b1;
        end else if (wrCtrl) begin
            faultIndEnable <= busReq.wdata[ofic_pkg::CTRL_FIEN];
            ocpEnable <= busReq.wdata[ofic_pkg::CTRL_OCPEN];
            ovpEnable <= busReq.wdata[ofic_pkg::CTRL_OVPEN];
        end
    end

    // indicator source; unknown codes fall back to none
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            faultSource <= ofic_pkg::FISRC_OFF;
        end else if (busReq.wr && busReq.addr == ofic_pkg::ADDR_FISRC) begin
            case (busReq.wdata[2:0])
                3'h1: faultSource <= ofic_pkg::FISRC_QUESTIONABLE_SUMMARY_CHOICE;
                3'h2: faultSource <= ofic_pkg::FISRC_OPERATION_SUMMARY_CHOICE;
                3'h3: faultSource <= ofic_pkg::FISRC_ESB;
                3'h4: faultSource <= ofic_pkg::FISRC_RQS;
                default: faultSource <= ofic_pkg::FISRC_OFF;
            endcase
        end
    end

    // constant current delay in milliseconds
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            delayMs <= 32'(DELAY_MS_RESET);
        end else if (busReq.wr && busReq.addr == ofic_pkg::ADDR_DELAY) begin
            delayMs <= busReq.wdata;
        end
    end

    // non-volatile settings: loaded from the store, written back on change
    assign next_nv = {5'h00, remote_disable_mode, ponChoice == ofic_pkg::PON_SLOT0};
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            remote_disable_mode <= ofic_pkg::RDM_OFF;
            ponChoice <= ofic_pkg::PON_RESET;
            nvWrite <= 1'b0;
            nvWriteData <= 8'h00;
        end else begin
            nvWrite <= 1'b0;
            if (nvLoad) begin
                ponChoice <= nvData[ofic_pkg::NV_PON] ? ofic_pkg::PON_SLOT0 : ofic_pkg::PON_RESET;
                remote_disable_mode <= ofic_pkg::ofic_mode_t'(nvData[ofic_pkg::NV_MODE_LSB +: 2]);
            end else if (busReq.wr && busReq.addr == ofic_pkg::ADDR_NVSET) begin
                ponChoice <= busReq.wdata[ofic_pkg::NV_PON] ? ofic_pkg::PON_SLOT0 : ofic_pkg::PON_RESET;
                remote_disable_mode <= ofic_pkg::ofic_mode_t'(busReq.wdata[ofic_pkg::NV_MODE_LSB +: 2]);
                nvWrite <= 1'b1;
                nvWriteData <= busReq.wdata[7:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            recall_slot_zero_poweron <= 1'b0;
        end else begin
            recall_slot_zero_poweron <= ponChoice == ofic_pkg::PON_SLOT0;
        end
    end

    // inhibit synchroniser; only inhSync is looked at
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            inhMeta <= 1'b1;
            inhSync <= 1'b1;
        end else begin
            inhMeta <= inhibitInput;
            inhSync <= inhMeta;
        end
    end

    // millisecond tick from the clock
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cycleCount <= 32'h00000000;
            msTick <= 1'b0;
        end else if (cycleCount >= 32'(CYCLES_PER_MS - 1)) begin
            cycleCount <= 32'h00000000;
            msTick <= 1'b1;
        end else begin
            cycleCount <= cycleCount + 32'h00000001;
            msTick <= 1'b0;
        end
    end

    // constant current is recorded only after it has stood for the delay
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            msCount <= 32'h00000000;
            ccRecorded <= 1'b0;
        end else if (!analogIn.ccRaw) begin
            msCount <= 32'h00000000;
            ccRecorded <= 1'b0;
        end else if (msCount >= delayMs) begin
            ccRecorded <= 1'b1;
        end else if (msTick) begin
            msCount <= msCount + 32'h00000001;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            constant_current_state <= 1'b0;
        end else begin
            constant_current_state <= ccRecorded;
        end
    end

    // protection latch; a fault in the clear cycle keeps the latch set
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            protLatched <= 1'b0;
        end else if (newFault) begin
            protLatched <= 1'b1;
        end else if (clearOk) begin
            protLatched <= 1'b0;
        end
    end

    // enable in effect when the first fault of a latch episode arrived
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            savedEnable <= 1'b0;
        end else if (newFault && !protLatched) begin
            savedEnable <= outEnable;
        end
    end

    // cause flags: each set by its own cause, dropped only by an accepted clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ocFlag <= 1'b0;
        end else if (ocpEnable && constant_current_state) begin
            ocFlag <= 1'b1;
        end else if (clearOk) begin
            ocFlag <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ovFlag <= 1'b0;
        end else if (ovpEnable && analogIn.overVoltage) begin
            ovFlag <= 1'b1;
        end else if (clearOk) begin
            ovFlag <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            otFlag <= 1'b0;
        end else if (analogIn.overTemp) begin
            otFlag <= 1'b1;
        end else if (clearOk) begin
            otFlag <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            inhibitLatched <= 1'b0;
        end else if (remote_disable_mode == ofic_pkg::RDM_LATCH && !inhSync) begin
            inhibitLatched <= 1'b1;
        end else if (clearOk) begin
            inhibitLatched <= 1'b0;
        end
    end

    // output stage; a fresh fault already holds it off in the cycle it is seen
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            outputOn <= 1'b0;
        end else begin
            outputOn <= outEnable && !protLatched && !newFault
                && !(remote_disable_mode == ofic_pkg::RDM_LIVE && !inhSync);
        end
    end

    // trip flags to the pins
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            overcurrent_trip <= 1'b0;
            overvoltage_trip <= 1'b0;
        end else begin
            overcurrent_trip <= ocFlag;
            overvoltage_trip <= ovFlag;
        end
    end

    always_comb begin
        case (faultSource)
            ofic_pkg::FISRC_QUESTIONABLE_SUMMARY_CHOICE: selectedFlag = statusByte[ofic_pkg::SB_QUESTIONABLE_SUMMARY_CHOICE];
            ofic_pkg::FISRC_OPERATION_SUMMARY_CHOICE: selectedFlag = statusByte[ofic_pkg::SB_OPERATION_SUMMARY_CHOICE];
            ofic_pkg::FISRC_ESB: selectedFlag = statusByte[ofic_pkg::SB_ESB];
            ofic_pkg::FISRC_RQS: selectedFlag = statusByte[ofic_pkg::SB_RQS];
            default: selectedFlag = 1'b0;
        endcase
    end

    // indicator level; gated by the enable so a released pin never carries a stale flag
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fault_indicator_out <= 1'b0;
        end else begin
            fault_indicator_out <= faultIndEnable && selectedFlag;
        end
    end

    // drive enable of the indicator pin
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            faultIndicatorOe <= 1'b0;
        end else begin
            faultIndicatorOe <= faultIndEnable;
        end
    end

    // read port, data one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            readData <= 32'h00000000;
        end else if (busReq.rd) begin
            case (busReq.addr)
                ofic_pkg::ADDR_CTRL: readData <= {28'h0000000, ovpEnable, ocpEnable, faultIndEnable, outEnable};
                ofic_pkg::ADDR_FISRC: readData <= {29'h00000000, faultSource};
                ofic_pkg::ADDR_DELAY: readData <= delayMs;
                ofic_pkg::ADDR_STATUS: readData <= {25'h0000000, inhSync, inhibitLatched, otFlag,
                    ovFlag, ocFlag, constant_current_state, protLatched};
                ofic_pkg::ADDR_NVSET: readData <= {24'h000000, next_nv};
                default: readData <= 32'h00000000;
            endcase
        end else begin
            readData <= 32'h00000000;
        end
    end
endmodule
`default_nettype wire

//--- testbench/ofic_monitor.sv
// Purpose: port checker for the output fault and inhibit block
// Assumes: one clock domain, async active-low reset
// Notes: attached by bind from the bench top
`timescale 1ns/10ps
`default_nettype none
module ofic_monitor (
    input wire logic mclk,
    input wire logic rst_n,
    input wire ofic_pkg::ofic_req_t busReq,
    input wire ofic_pkg::ofic_analog_t analogIn,
    input wire logic [7:0] statusByte,
    input wire logic nvLoad,
    input wire logic [7:0] nvData,
    input wire logic outputOn,
    input wire logic fault_indicator_out,
    input wire logic faultIndicatorOe,
    input wire logic constant_current_state,
    input wire logic overcurrent_trip,
    input wire logic overvoltage_trip,
    input wire logic recall_slot_zero_poweron,
    input wire logic nvWrite,
    input wire logic [7:0] nvWriteData
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    fi_oe_a: assert property (fault_indicator_out |-> faultIndicatorOe)
        else $error("indicator active while not driven");
    fi_cause_a: assert property ($rose(fault_indicator_out) |-> |($past(statusByte) & 8'hE8))
        else $error("indicator rose without a summary flag");
    ov_cause_a: assert property ($rose(overvoltage_trip) |-> $past(analogIn.overVoltage, 2))
        else $error("overvoltage trip without cause");
    oc_cause_a: assert property ($rose(overcurrent_trip) |->
        $past(constant_current_state, 2))
        else $error("overcurrent trip without recorded cc");
    cc_cause_a: assert property (constant_current_state |-> $past(analogIn.ccRaw, 2))
        else $error("cc recorded without raw cc");
    trip_off_a: assert property ((overvoltage_trip || overcurrent_trip) &&
        $past(overvoltage_trip || overcurrent_trip) |-> !outputOn)
        else $error("output on while tripped");
    rise_clean_a: assert property ($rose(outputOn) |-> !overvoltage_trip && !overcurrent_trip)
        else $error("output rose with a trip flag set");
    nv_load_a: assert property (nvLoad |-> ##2 recall_slot_zero_poweron == $past(nvData[0], 2))
        else $error("power-on choice not loaded");
    nv_write_a: assert property (busReq.wr && busReq.addr == ofic_pkg::ADDR_NVSET |=>
        nvWrite && nvWriteData == $past(busReq.wdata[7:0]))
        else $error("stored settings not written out");
    clr_hold_a: assert property (busReq.wr && busReq.addr == ofic_pkg::ADDR_CMD && busReq.wdata[0] &&
        analogIn.overVoltage && overvoltage_trip |=> overvoltage_trip)
        else $error("clear accepted with cause present");
    ov_seen_c: cover property ($rose(overvoltage_trip));
    cc_seen_c: cover property ($rose(constant_current_state));
    fi_seen_c: cover property ($rose(fault_indicator_out));
endmodule
`default_nettype wire

//--- testbench/ofic_far_model.sv
// Purpose: external wiring on the inhibit and indicator lines
// Assumes: indicator line has a pull-down
// Notes: inhibit pin changes just after a clock edge
`timescale 1ns/10ps
`default_nettype none
module ofic_far_model (
    input wire logic mclk,
    input wire logic inhLow,
    input wire logic fault_indicator_out,
    input wire logic faultIndicatorOe,
    output logic inhibitInput,
    output logic indicatorLine
);
    always_ff @(posedge mclk) begin
        inhibitInput <= !inhLow;
    end
    // released line falls to the pull-down level
    assign indicatorLine = faultIndicatorOe ? fault_indicator_out : 1'b0;
endmodule
`default_nettype wire

//--- testbench/tb.sv
// Purpose: self-checking bench for the output fault and inhibit block
// Assumes: ms tick shortened to 10 cycles
// Notes: status bytes drawn from a fixed seed
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic mclk, rst_n, inhLow, nvLoad, inhPin, fiLine, oOn, fiOut, fiOe, cst, ocT, ovT, pon;
    ofic_pkg::ofic_req_t req;
    ofic_pkg::ofic_analog_t ana;
    logic [7:0] sb, nvData;
    logic [31:0] rdata;
    int fail_count, cmp_count, seed, m, s;
    output_fault_inhibit_control #(.CYCLES_PER_MS(10)) i_dut (.mclk(mclk), .rst_n(rst_n), .busReq(req),
        .readData(rdata), .analogIn(ana), .statusByte(sb), .inhibitInput(inhPin), .nvLoad(nvLoad),
        .nvData(nvData), .outputOn(oOn), .fault_indicator_out(fiOut), .faultIndicatorOe(fiOe),
        .constant_current_state(cst), .overcurrent_trip(ocT), .overvoltage_trip(ovT),
        .recall_slot_zero_poweron(pon), .nvWrite(), .nvWriteData());
    ofic_far_model i_far (.mclk(mclk), .inhLow(inhLow), .fault_indicator_out(fiOut),
        .faultIndicatorOe(fiOe), .inhibitInput(inhPin), .indicatorLine(fiLine));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask
    task rdc(input logic [3:0] a, input logic [31:0] e, input string n);
        @(posedge mclk);
        req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge mclk);
        req.rd <= 1'b0;
        #1 chk(n, e, rdata);
    endtask
    function logic fiExp(input int src, input logic [7:0] b);
        case (src)
            1: return b[3];
            2: return b[7];
            3: return b[5];
            4: return b[6];
            default: return 1'b0;
        endcase
    endfunction
    task final_report;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #3000000;
        fail_count++;
        final_report;
    end
    initial begin
        seed = 68;
        rst_n = 1'b0;
        req = '0;
        ana = '0;
        sb = 8'h00;
        inhLow = 1'b0;
        nvLoad = 1'b0;
        nvData = 8'h00;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        rdc(4'h0, 32'h8, "ctrl");
        rdc(4'h1, 32'h0, "source");
        rdc(4'h2, 32'd80, "delay");
        rdc(4'hF, 32'h0, "unmapped");
        $display("test reset done");
        wr(4'h1, 32'h2);
        @(posedge mclk) sb <= 8'hFF;
        cyc(2);
        chk("fiLine", 0, fiLine);
        wr(4'h0, 32'hA);
        repeat (4) for (s = 0; s < 5; s++) begin
            wr(4'h1, s);
            @(posedge mclk) sb <= 8'($random(seed));
            cyc(2);
            chk("fi", fiExp(s, sb), fiLine);
        end
        $display("test indicator done");
        wr(4'h0, 32'h9);
        cyc(2);
        chk("outputOn", 1, oOn);
        @(posedge mclk) ana <= '{1'b1, 1'b0, 1'b0};
        cyc(3);
        chk("ovTrip", 1, ovT);
        chk("outputOn", 0, oOn);
        wr(4'h3, 32'h1);
        cyc(3);
        chk("ovHeld", 1, ovT);
        @(posedge mclk) ana <= '0;
        wr(4'h3, 32'h1);
        cyc(3);
        chk("ovClear", 0, ovT);
        chk("restored", 1, oOn);
        wr(4'h2, 32'd3);
        wr(4'h0, 32'hD);
        @(posedge mclk) ana <= '{1'b0, 1'b0, 1'b1};
        cyc(20);
        chk("ocEarly", 0, ocT);
        cyc(20);
        chk("ocTrip", 1, ocT);
        chk("outputOn", 0, oOn);
        @(posedge mclk) ana <= '0;
        cyc(3);
        wr(4'h3, 32'h1);
        cyc(3);
        chk("restored", 1, oOn);
        $display("test protection done");
        for (m = 0; m < 3; m++) begin
            @(posedge mclk);
            nvData <= 8'({m[1:0], m[0]});
            nvLoad <= 1'b1;
            @(posedge mclk);
            nvLoad <= 1'b0;
            inhLow <= 1'b1;
            cyc(6);
            chk("pon", m[0], pon);
            chk("inhLow", m == 0, oOn);
            wr(4'h3, 32'h1);
            cyc(3);
            chk("clrRefused", m == 0, oOn);
            @(posedge mclk) inhLow <= 1'b0;
            cyc(6);
            chk("inhHigh", m != 1, oOn);
            wr(4'h3, 32'h1);
            cyc(4);
            chk("inhClear", 1, oOn);
        end
        wr(4'h5, 32'h4);
        rdc(4'h5, 32'h4, "nvStore");
        $display("test inhibit done");
        final_report;
    end
endmodule
bind output_fault_inhibit_control ofic_monitor i_mon (.mclk(mclk), .rst_n(rst_n), .busReq(busReq),
    .analogIn(analogIn), .statusByte(statusByte), .nvLoad(nvLoad), .nvData(nvData), .outputOn(outputOn),
    .fault_indicator_out(fault_indicator_out), .faultIndicatorOe(faultIndicatorOe),
    .constant_current_state(constant_current_state), .overcurrent_trip(overcurrent_trip),
    .overvoltage_trip(overvoltage_trip), .recall_slot_zero_poweron(recall_slot_zero_poweron),
    .nvWrite(nvWrite), .nvWriteData(nvWriteData));
`default_nettype wire
